// File: hw/crd_pkg.sv
package crd_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CRD_CLK_MHZ     = 200;
  localparam int unsigned CRD_RST_MIN_US  = 50;
  // Least time, whole microseconds at an integral MHz: exact, no rounding
  localparam int unsigned CRD_RST_MIN_CYC = CRD_RST_MIN_US * CRD_CLK_MHZ;
  localparam int unsigned CRD_CHOP_DIV    = 100;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int CRD_NCH      = 4;
  localparam int CRD_SLOT_W   = 7;
  localparam int CRD_COEF_N   = 32;
  localparam int CRD_BLK_WRDS = 8;
  localparam int CRD_BLK3_IDX = 16;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] CRD_OFF_CTRL    = 12'h000;
  localparam logic [11:0] CRD_OFF_STATUS  = 12'h004;
  localparam logic [11:0] CRD_OFF_GLB     = 12'h008;
  localparam logic [11:0] CRD_OFF_LOOP    = 12'h00C;
  localparam logic [11:0] CRD_OFF_CHAN0   = 12'h010;
  localparam logic [11:0] CRD_OFF_FILT    = 12'h020;
  localparam logic [11:0] CRD_OFF_SLIC    = 12'h024;
  localparam logic [11:0] CRD_OFF_IRQ_EN  = 12'h028;
  localparam logic [11:0] CRD_OFF_IRQ_PND = 12'h02C;
  localparam logic [11:0] CRD_OFF_FEAT    = 12'h030;
  localparam logic [11:0] CRD_OFF_CF_ADDR = 12'h034;
  localparam logic [11:0] CRD_OFF_CF_DATA = 12'h038;
  localparam logic [11:0] CRD_OFF_CF_RD   = 12'h03C;

  // ****************************************************************
  // Field positions (glb: mclk[3:0] law[4] rate[5] txedge[6] rxedge[7]
  // chopa[11:8] chopb[13:12]; chan: txslot[6:0] txhwy[7] rxslot[14:8]
  // rxhwy[15] powerup[16]; slic: dira[3:0] dirb[7:4] dirc[11:8]
  // deba[15:12] debb[19:16]; filt bit 7 is the high-pass filter)
  // ****************************************************************
  localparam int CRD_CTRL_SOFT  = 0;
  localparam int CRD_GLB_W      = 14;
  localparam int CRD_CHAN_W     = 17;
  localparam int CRD_CHAN_PUP   = 16;
  localparam int CRD_LOOP_W     = 7;
  localparam int CRD_SLIC_W     = 20;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0]            CRD_MCLK_2048 = 4'h2;
  localparam logic [CRD_GLB_W-1:0]  CRD_GLB_DEF   = {10'h000, CRD_MCLK_2048};
  localparam logic [CRD_LOOP_W-1:0] CRD_LOOP_DEF  = 7'h00;
  localparam logic [7:0]            CRD_FILT_DEF  = 8'h80;
  localparam logic [CRD_SLIC_W-1:0] CRD_SLIC_DEF  = 20'h00000;
  localparam logic [7:0]            CRD_IRQ_DEF   = 8'h00;
  localparam logic [3:0]            CRD_FEAT_DEF  = 4'h0;

  typedef enum logic [1:0] {
    CRD_RUN,
    CRD_PIN_HOLD,
    CRD_SOFT
  } crd_rst_state_e;

endpackage

// File: hw/crd_pin_filter.sv
`timescale 1ns/10ps
module crd_pin_filter #(
  parameter int unsigned MIN_CYC = 10000
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin_n,
  output logic      hold
);
  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] MIN_C = CW'(MIN_CYC);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          hold_reg;
  logic          hold_next;

  // Count saturates so a long hold never wraps back out of reset
  assign cnt_next  = pin_n ? '0 : ((cnt_reg == MIN_C) ? cnt_reg : cnt_reg + 1'b1);
  // Release is taken on the clock edge, never straight from the pin
  assign hold_next = ~pin_n & (cnt_next == MIN_C);
  assign hold      = hold_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= '0;
      hold_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      hold_reg <= hold_next;
    end
  end

  chk_hold_min_low: assert property (@(posedge clk) disable iff (!rstn)
    $rose(hold_reg) |-> $past(cnt_reg) == MIN_C - 1'b1) else $error("hold before min low");
  chk_hold_release: assert property (@(posedge clk) disable iff (!rstn)
    $fell(hold_reg) |-> $past(pin_n)) else $error("hold dropped while pin low");

endmodule // crd_pin_filter

// File: hw/crd_coef_ram.sv
`timescale 1ns/10ps
module crd_coef_ram
  import crd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  input  wire logic [4:0]  rd_idx,
  output logic [15:0]      rd_data,
  input  wire logic        ptr_clr,
  input  wire logic        ptr_adv,
  output logic [7:0]       rd_byte
);
  logic [15:0] mem [CRD_COEF_N];
  logic [3:0]  ptr_reg;
  logic [4:0]  byte_word;

  // No reset on storage: contents survive every reset type
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_reg <= 4'h0;
    end else if (ptr_clr) begin
      ptr_reg <= 4'h0;
    end else if (ptr_adv) begin
      ptr_reg <= ptr_reg + 4'h1;
    end
  end

  // Word 8 down to word 1, high byte first
  assign byte_word = 5'(CRD_BLK3_IDX + CRD_BLK_WRDS - 1) - {2'b00, ptr_reg[3:1]};
  assign rd_byte   = ptr_reg[0] ? mem[byte_word][7:0] : mem[byte_word][15:8];
  assign rd_data   = mem[rd_idx];

  chk_last_byte: assert property (@(posedge clk) disable iff (!rstn)
    ptr_reg == 4'hF |-> rd_byte == mem[CRD_BLK3_IDX][7:0]) else $error("last byte order");
  chk_ram_kept: assert property (@(posedge clk) disable iff (!rstn)
    (!wr_en ##1 $stable(rd_idx)) |-> $stable(rd_data)) else $error("ram changed");

endmodule // crd_coef_ram

// File: hw/crd_reset_default.sv
`timescale 1ns/10ps
module crd_reset_default
  import crd_pkg::*;
#(
  parameter int unsigned RST_MIN_CYC = CRD_RST_MIN_CYC
) (
  input  wire logic               CLK,
  input  wire logic               RSTN,
  input  wire logic               PIN_RESET_N,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [11:0]        PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic                    PREADY,
  output logic [31:0]             PRDATA,
  output logic                    PSLVERR,
  input  wire logic [7:0]         IRQ_EVENT,
  output logic [7:0]              IRQ_PENDING,
  output logic [7:0]              IRQ_SRC_EN,
  output logic [crd_pkg::CRD_NCH-1:0] CH_POWER_DOWN,
  output logic [crd_pkg::CRD_NCH-1:0] TX_HWY_SEL,
  output logic [crd_pkg::CRD_NCH-1:0] RX_HWY_SEL,
  output logic [27:0]             TX_SLOT,
  output logic [27:0]             RX_SLOT,
  output logic [3:0]              MCLK_SEL,
  output logic                    COMPAND_MU,
  output logic                    RATE_DOUBLE,
  output logic                    TX_EDGE_FALL,
  output logic                    RX_EDGE_RISE,
  output logic [5:0]              LOOPBACK_EN,
  output logic                    CUTOFF_EN,
  output logic [7:0]              FILTER_EN,
  output logic [3:0]              SLIC_BIDIR_A_OUT,
  output logic [3:0]              SLIC_BIDIR_B_OUT,
  output logic [3:0]              SLIC_BIDIR_C_OUT,
  output logic [3:0]              SLIC_INPUT_A_DEB,
  output logic [3:0]              SLIC_INPUT_B_DEB,
  output logic [3:0]              FEATURE_EN,
  output logic                    CHOPPER_CLOCK_OUT_A,
  output logic                    CHOPPER_CLOCK_OUT_B,
  output logic                    IN_RESET
);

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  logic           pin_hold;
  crd_rst_state_e state_reg;
  crd_rst_state_e state_next;
  logic           in_rst;

  crd_pin_filter #(
    .MIN_CYC (RST_MIN_CYC)
  ) u_pin (
    .clk   (CLK),
    .rstn  (RSTN),
    .pin_n (PIN_RESET_N),
    .hold  (pin_hold)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        access;
  logic        done;
  logic        wr_ok;
  logic        hit_ctrl, hit_stat, hit_glb, hit_loop, hit_chan, hit_filt;
  logic        hit_slic, hit_ien, hit_ipnd, hit_feat, hit_cfa, hit_cfd, hit_cfr;
  logic        mapped;
  logic [1:0]  ch_idx;
  logic [31:0] rd_mux;

  assign access   = PSEL & PENABLE;
  assign done     = access & pready_reg;
  // Writes are dropped while defaults are being forced
  assign wr_ok    = done & PWRITE & mapped & ~in_rst;
  assign hit_ctrl = PADDR == CRD_OFF_CTRL;
  assign hit_stat = PADDR == CRD_OFF_STATUS;
  assign hit_glb  = PADDR == CRD_OFF_GLB;
  assign hit_loop = PADDR == CRD_OFF_LOOP;
  assign hit_chan = (PADDR[11:4] == CRD_OFF_CHAN0[11:4]) & (PADDR[1:0] == 2'b00);
  assign hit_filt = PADDR == CRD_OFF_FILT;
  assign hit_slic = PADDR == CRD_OFF_SLIC;
  assign hit_ien  = PADDR == CRD_OFF_IRQ_EN;
  assign hit_ipnd = PADDR == CRD_OFF_IRQ_PND;
  assign hit_feat = PADDR == CRD_OFF_FEAT;
  assign hit_cfa  = PADDR == CRD_OFF_CF_ADDR;
  assign hit_cfd  = PADDR == CRD_OFF_CF_DATA;
  assign hit_cfr  = PADDR == CRD_OFF_CF_RD;
  assign mapped   = hit_ctrl | hit_stat | hit_glb | hit_loop | hit_chan | hit_filt |
                    hit_slic | hit_ien | hit_ipnd | hit_feat | hit_cfa | hit_cfd | hit_cfr;
  assign ch_idx   = PADDR[3:2];

  // ****************************************************************
  // Reset state machine
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CRD_RUN: begin
        if (pin_hold) begin
          state_next = CRD_PIN_HOLD;
        end else if (wr_ok & hit_ctrl & PWDATA[CRD_CTRL_SOFT]) begin
          state_next = CRD_SOFT;
        end
      end
      CRD_PIN_HOLD: begin
        if (!pin_hold) begin
          state_next = CRD_RUN;
        end
      end
      CRD_SOFT: begin
        state_next = pin_hold ? CRD_PIN_HOLD : CRD_RUN;
      end
      default: begin
        state_next = CRD_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= CRD_RUN;
      in_rst    <= 1'b0;
    end else begin
      state_reg <= state_next;
      in_rst    <= state_next != CRD_RUN;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Power-on (RSTN) and the synchronous default path load the same values
  logic [CRD_GLB_W-1:0]  glb_reg;
  logic [CRD_LOOP_W-1:0] loop_reg;
  logic [7:0]            filt_reg;
  logic [CRD_SLIC_W-1:0] slic_reg;
  logic [7:0]            ien_reg;
  logic [7:0]            ipnd_reg;
  logic [7:0]            ipnd_next;
  logic [3:0]            feat_reg;
  logic [4:0]            cfa_reg;
  logic [CRD_CHAN_W-1:0] chan_reg [CRD_NCH];

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      glb_reg  <= CRD_GLB_DEF;
      loop_reg <= CRD_LOOP_DEF;
      filt_reg <= CRD_FILT_DEF;
      slic_reg <= CRD_SLIC_DEF;
      ien_reg  <= CRD_IRQ_DEF;
      feat_reg <= CRD_FEAT_DEF;
      cfa_reg  <= 5'h00;
    end else if (in_rst) begin
      glb_reg  <= CRD_GLB_DEF;
      loop_reg <= CRD_LOOP_DEF;
      filt_reg <= CRD_FILT_DEF;
      slic_reg <= CRD_SLIC_DEF;
      ien_reg  <= CRD_IRQ_DEF;
      feat_reg <= CRD_FEAT_DEF;
      cfa_reg  <= 5'h00;
    end else if (wr_ok) begin
      if (hit_glb)  glb_reg  <= PWDATA[CRD_GLB_W-1:0];
      if (hit_loop) loop_reg <= PWDATA[CRD_LOOP_W-1:0];
      if (hit_filt) filt_reg <= PWDATA[7:0];
      if (hit_slic) slic_reg <= PWDATA[CRD_SLIC_W-1:0];
      if (hit_ien)  ien_reg  <= PWDATA[7:0];
      if (hit_feat) feat_reg <= PWDATA[3:0];
      if (hit_cfa)  cfa_reg  <= PWDATA[4:0];
    end
  end

  // Set wins over a write-one clear in the same cycle
  assign ipnd_next = in_rst ? CRD_IRQ_DEF :
                     ((ipnd_reg & ~((wr_ok & hit_ipnd) ? PWDATA[7:0] : 8'h00)) |
                      (IRQ_EVENT & ien_reg));

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ipnd_reg <= CRD_IRQ_DEF;
    end else begin
      ipnd_reg <= ipnd_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CRD_NCH; gi++) begin : g_chan
      // Slot n-1, first highways, powered down
      localparam logic [CRD_CHAN_W-1:0] CH_DEF = {1'b0, 1'b0, 7'(gi), 1'b0, 7'(gi)};
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          chan_reg[gi] <= CH_DEF;
        end else if (in_rst) begin
          chan_reg[gi] <= CH_DEF;
        end else if (wr_ok & hit_chan & (ch_idx == 2'(gi))) begin
          chan_reg[gi] <= PWDATA[CRD_CHAN_W-1:0];
        end
      end
      assign CH_POWER_DOWN[gi]          = ~chan_reg[gi][CRD_CHAN_PUP];
      assign TX_SLOT[gi*7 +: 7]         = chan_reg[gi][6:0];
      assign TX_HWY_SEL[gi]             = chan_reg[gi][7];
      assign RX_SLOT[gi*7 +: 7]         = chan_reg[gi][14:8];
      assign RX_HWY_SEL[gi]             = chan_reg[gi][15];
    end
  endgenerate

  // ****************************************************************
  // Coefficient RAM
  // ****************************************************************
  logic [15:0] cf_rdata;
  logic [7:0]  cf_byte;
  logic        cf_clr;
  logic        cf_adv;

  // Readout pointer clears on any reset so a readout restarts at byte 1
  assign cf_clr = in_rst | (wr_ok & hit_cfr);
  assign cf_adv = done & ~PWRITE & hit_cfr;

  crd_coef_ram u_ram (
    .clk     (CLK),
    .rstn    (RSTN),
    .wr_en   (wr_ok & hit_cfd),
    .wr_idx  (cfa_reg),
    .wr_data (PWDATA[15:0]),
    .rd_idx  (cfa_reg),
    .rd_data (cf_rdata),
    .ptr_clr (cf_clr),
    .ptr_adv (cf_adv),
    .rd_byte (cf_byte)
  );

  // ****************************************************************
  // Chopper clocks
  // ****************************************************************
  localparam int DW = $clog2(CRD_CHOP_DIV);
  logic [DW-1:0] div_reg;
  logic          chop_tick;
  logic          chop_a_reg;
  logic          chop_b_reg;

  assign chop_tick = div_reg == DW'(CRD_CHOP_DIV - 1);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_reg    <= '0;
      chop_a_reg <= 1'b1;
      chop_b_reg <= 1'b1;
    end else begin
      div_reg    <= chop_tick ? '0 : div_reg + 1'b1;
      // Idle level high whenever a chopper is not selected
      chop_a_reg <= (in_rst | ~|glb_reg[11:8]) ? 1'b1 : (chop_a_reg ^ chop_tick);
      chop_b_reg <= (in_rst | ~|glb_reg[13:12]) ? 1'b1 : (chop_b_reg ^ chop_tick);
    end
  end

  // ****************************************************************
  // Read path, one wait state so read data leaves a flop
  // ****************************************************************
  assign rd_mux = hit_stat ? {29'h0, pin_hold, in_rst, ~PIN_RESET_N} :
                  hit_glb  ? {18'h0, glb_reg} :
                  hit_loop ? {25'h0, loop_reg} :
                  hit_chan ? {15'h0, chan_reg[ch_idx]} :
                  hit_filt ? {24'h0, filt_reg} :
                  hit_slic ? {12'h0, slic_reg} :
                  hit_ien  ? {24'h0, ien_reg} :
                  hit_ipnd ? {24'h0, ipnd_reg} :
                  hit_feat ? {28'h0, feat_reg} :
                  hit_cfa  ? {27'h0, cfa_reg} :
                  hit_cfd  ? {16'h0, cf_rdata} :
                  hit_cfr  ? {24'h0, cf_byte} : 32'h0;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~mapped;
      if (access & ~pready_reg & ~PWRITE) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  assign PREADY       = pready_reg;
  assign PRDATA       = prdata_reg;
  assign PSLVERR      = pslverr_reg;
  assign IRQ_PENDING  = ipnd_reg;
  assign IRQ_SRC_EN   = ien_reg;
  assign MCLK_SEL     = glb_reg[3:0];
  assign COMPAND_MU   = glb_reg[4];
  assign RATE_DOUBLE  = glb_reg[5];
  assign TX_EDGE_FALL = glb_reg[6];
  assign RX_EDGE_RISE = glb_reg[7];
  assign LOOPBACK_EN  = loop_reg[5:0];
  assign CUTOFF_EN    = loop_reg[6];
  assign FILTER_EN    = filt_reg;
  assign SLIC_BIDIR_A_OUT = slic_reg[3:0];
  assign SLIC_BIDIR_B_OUT = slic_reg[7:4];
  assign SLIC_BIDIR_C_OUT = slic_reg[11:8];
  assign SLIC_INPUT_A_DEB = slic_reg[15:12];
  assign SLIC_INPUT_B_DEB = slic_reg[19:16];
  assign FEATURE_EN   = feat_reg;
  assign CHOPPER_CLOCK_OUT_A = chop_a_reg;
  assign CHOPPER_CLOCK_OUT_B = chop_b_reg;
  assign IN_RESET     = in_rst;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence soft_cmd_s;
    wr_ok & hit_ctrl & PWDATA[CRD_CTRL_SOFT] & ~pin_hold;
  endsequence
  sequence soft_done_s;
    in_rst ##1 (~in_rst & glb_reg == CRD_GLB_DEF & FILTER_EN == CRD_FILT_DEF);
  endsequence

  chk_pin_enter: assert property (pin_hold |=> in_rst) else $error("pin no reset");
  chk_soft_seq: assert property (soft_cmd_s |=> soft_done_s) else $error("soft reset wrong");
  chk_ch_down: assert property (in_rst |=> CH_POWER_DOWN == 4'hF) else $error("channel up");
  chk_loop_off: assert property (in_rst |=> LOOPBACK_EN == 6'h00 && !CUTOFF_EN)
    else $error("loopback on");
  chk_hwy_first: assert property (in_rst |=> TX_HWY_SEL == 4'h0 && RX_HWY_SEL == 4'h0)
    else $error("highway not first");
  chk_mclk_def: assert property (in_rst |=> MCLK_SEL == CRD_MCLK_2048) else $error("mclk");
  chk_slot_def: assert property (in_rst |=> TX_SLOT == 28'h0608080 && RX_SLOT == 28'h0608080)
    else $error("slot default");
  chk_edge_def: assert property (in_rst |=> !RATE_DOUBLE && !TX_EDGE_FALL && !RX_EDGE_RISE)
    else $error("edge default");
  chk_law_def: assert property ($fell(in_rst) |-> !COMPAND_MU) else $error("not a-law");
  chk_filt_def: assert property (in_rst |=> FILTER_EN == 8'h80) else $error("filters");
  chk_slic_dir: assert property (in_rst |=> {SLIC_BIDIR_A_OUT, SLIC_BIDIR_B_OUT,
    SLIC_BIDIR_C_OUT} == 12'h000) else $error("slic output");
  chk_slic_deb: assert property (in_rst |=> {SLIC_INPUT_A_DEB, SLIC_INPUT_B_DEB} == 8'h00)
    else $error("debounce on");
  chk_irq_clear: assert property (in_rst |=> IRQ_PENDING == 8'h00 && IRQ_SRC_EN == 8'h00)
    else $error("irq after reset");
  chk_feat_off: assert property (in_rst |=> FEATURE_EN == 4'h0) else $error("feature on");
  chk_chop_high: assert property (in_rst |=> CHOPPER_CLOCK_OUT_A && CHOPPER_CLOCK_OUT_B)
    else $error("chopper low");
  chk_sync_exit: assert property ($fell(pin_hold) |=> !in_rst) else $error("late exit");

endmodule // crd_reset_default

// File: dv/crd_host_model.sv
`timescale 1ns/10ps
module crd_host_model (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [15:0] low_cyc,
  output logic             pin_n
);
  // ****************************************************************
  // Reset pin sequencing
  // ****************************************************************
  // Power-up: pin low from time zero, released later
  logic [15:0] cnt_reg = 16'h0028;
  always @(posedge clk) begin
    if (start) begin
      cnt_reg <= low_cyc;
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end
  assign pin_n = (cnt_reg == 16'h0000);
endmodule // crd_host_model

// File: dv/test_crd_reset_default.sv
`timescale 1ns/10ps
module test_crd_reset_default;
  import crd_pkg::*;
  logic CLK, RSTN, PIN_RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd_q;
  logic [7:0] IRQ_EVENT, IRQ_PENDING, IRQ_SRC_EN, FILTER_EN;
  logic [3:0] CH_POWER_DOWN, TX_HWY_SEL, RX_HWY_SEL, MCLK_SEL, FEATURE_EN;
  logic [3:0] SBA, SBB, SBC, DBA, DBB;
  logic [27:0] TX_SLOT, RX_SLOT;
  logic [5:0] LOOPBACK_EN;
  logic COMPAND_MU, RATE_DOUBLE, TX_EDGE_FALL, RX_EDGE_RISE, CUTOFF_EN;
  logic CHA, CHB, IN_RESET, err_q, start;
  logic [15:0] low_cyc;
  int bad_count, total_checks;
  crd_reset_default #(.RST_MIN_CYC(20)) DUT (.CLK(CLK), .RSTN(RSTN),
    .PIN_RESET_N(PIN_RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .IRQ_EVENT(IRQ_EVENT), .IRQ_PENDING(IRQ_PENDING), .IRQ_SRC_EN(IRQ_SRC_EN),
    .CH_POWER_DOWN(CH_POWER_DOWN), .TX_HWY_SEL(TX_HWY_SEL), .RX_HWY_SEL(RX_HWY_SEL),
    .TX_SLOT(TX_SLOT), .RX_SLOT(RX_SLOT), .MCLK_SEL(MCLK_SEL), .COMPAND_MU(COMPAND_MU),
    .RATE_DOUBLE(RATE_DOUBLE), .TX_EDGE_FALL(TX_EDGE_FALL), .RX_EDGE_RISE(RX_EDGE_RISE),
    .LOOPBACK_EN(LOOPBACK_EN), .CUTOFF_EN(CUTOFF_EN), .FILTER_EN(FILTER_EN),
    .SLIC_BIDIR_A_OUT(SBA), .SLIC_BIDIR_B_OUT(SBB), .SLIC_BIDIR_C_OUT(SBC),
    .SLIC_INPUT_A_DEB(DBA), .SLIC_INPUT_B_DEB(DBB), .FEATURE_EN(FEATURE_EN),
    .CHOPPER_CLOCK_OUT_A(CHA), .CHOPPER_CLOCK_OUT_B(CHB), .IN_RESET(IN_RESET));
  crd_host_model host (.clk(CLK), .start(start), .low_cyc(low_cyc), .pin_n(PIN_RESET_N));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  always #2.5 CLK = ~CLK;
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'h1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'h1);
    rd_q = PRDATA;
    err_q = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task automatic defaults();
    chk("pwrdn", 32'hF, CH_POWER_DOWN);
    chk("loop", 32'h0, {CUTOFF_EN, LOOPBACK_EN});
    chk("hwy", 32'h0, {TX_HWY_SEL, RX_HWY_SEL});
    chk("mclk", 32'h2, MCLK_SEL);
    chk("txslot", {7'h03, 7'h02, 7'h01, 7'h00}, TX_SLOT);
    chk("rxslot", {7'h03, 7'h02, 7'h01, 7'h00}, RX_SLOT);
    chk("pcm", 32'h0, {RATE_DOUBLE, TX_EDGE_FALL, RX_EDGE_RISE});
    chk("law", 32'h0, COMPAND_MU);
    chk("filt", 32'h80, FILTER_EN);
    chk("sbdir", 32'h0, {SBA, SBB, SBC});
    chk("deb", 32'h0, {DBA, DBB});
    chk("irq", 32'h0, {IRQ_SRC_EN, IRQ_PENDING});
    chk("feat", 32'h0, FEATURE_EN);
    chk("chop", 32'h3, {CHA, CHB});
    apb(1'h0, CRD_OFF_GLB, 32'h0);
    chk("glb", 32'h2, rd_q);
  endtask
  task automatic rdout();
    for (int j = 0; j < 16; j++) begin
      apb(1'h0, CRD_OFF_CF_RD, 32'h0);
      chk("byte", (j % 2) ? 8'hC8 - j / 2 : 8'hB8 - j / 2, rd_q[7:0]);
    end
  endtask
  task automatic scramble();
    apb(1'h1, CRD_OFF_GLB, 32'h3FFF);
    apb(1'h1, CRD_OFF_LOOP, 32'h7F);
    for (int c = 0; c < 4; c++) apb(1'h1, CRD_OFF_CHAN0 + 12'(4 * c), 32'h1FFFF);
    apb(1'h1, CRD_OFF_FILT, 32'h7F);
    apb(1'h1, CRD_OFF_SLIC, 32'hFFFFF);
    apb(1'h1, CRD_OFF_FEAT, 32'hF);
    apb(1'h1, CRD_OFF_IRQ_EN, 32'hFF);
    IRQ_EVENT <= 8'hFF;
    @(posedge CLK);
    IRQ_EVENT <= 8'h00;
    repeat (3) @(posedge CLK);
    chk("pend", 32'hFF, IRQ_PENDING);
  endtask
  task automatic pulse(logic [15:0] n, logic exp);
    start <= 1'h1;
    low_cyc <= n;
    @(posedge CLK);
    start <= 1'h0;
    repeat (n + 1) @(posedge CLK);
    #1 chk("in_reset", exp, IN_RESET);
    repeat (30) @(posedge CLK);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
  initial begin
    CLK = 0; RSTN = 0; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0; PWDATA = 0;
    IRQ_EVENT = 0; start = 0; low_cyc = 0; bad_count = 0; total_checks = 0;
    repeat (10) @(posedge CLK);
    RSTN <= 1'h1;
    // Host keeps the pin low past power-up before any access
    repeat (60) @(posedge CLK);
    defaults();
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, CRD_OFF_CF_ADDR, 32'(16 + i));
      apb(1'h1, CRD_OFF_CF_DATA, {16'h0, 8'hB1 + 8'(i), 8'hC1 + 8'(i)});
    end
    rdout();
    scramble();
    apb(1'h1, CRD_OFF_CTRL, 32'h1);
    repeat (4) @(posedge CLK);
    defaults();
    rdout();
    scramble();
    pulse(16'd10, 1'h0);
    apb(1'h0, CRD_OFF_GLB, 32'h0);
    chk("glb_kept", 32'h3FFF, rd_q);
    RSTN <= 1'h0;
    repeat (3) @(posedge CLK);
    RSTN <= 1'h1;
    repeat (2) @(posedge CLK);
    defaults();
    rdout();
    scramble();
    pulse(16'd25, 1'h1);
    defaults();
    rdout();
    apb(1'h0, 12'h0FC, 32'h0);
    chk("slverr", 32'h1, err_q);
    conclude();
  end
endmodule // test_crd_reset_default
